// File: core/dua_pins.sv
// Channel A serial engine, general outputs, master reset and data bus.
// Assumes asynchronous host strobes; all pins but the clock, nrst_i and clk_en_i are synchronised first.
`timescale 1ns/1ps
`default_nettype none
module dua_pins
  import dua_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic master_reset_i,
  input wire logic chip_sel_n_i,
  input wire logic rd_strobe_i,
  input wire logic wr_strobe_i,
  input wire logic [2:0] reg_sel_i,
  input wire logic [7:0] data_i,
  input wire logic z_mode_i,
  input wire logic interrupt_acknowledge_n_i,
  input wire logic serial_in_a_i,
  input wire logic ext_transmit_clock_a_i,
  input wire logic ext_receive_clock_a_i,
  input wire logic general_input_2_i,
  input wire logic general_input_6_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic serial_out_a_o,
  output logic serial_out_b_o,
  output logic ext_receive_clock_b_o,
  output logic [7:0] general_outputs_all_o,
  output logic [7:0] general_outputs_oe_o
);

  // Pin capture: every pin but the clock, nrst_i and clk_en_i crosses two flops first
  logic [PIN_W-1:0] pin_raw, pin_s, prev_ff;
  assign pin_raw = {general_input_6_i, general_input_2_i,
    ext_receive_clock_a_i, ext_transmit_clock_a_i, serial_in_a_i,
    master_reset_i, z_mode_i, interrupt_acknowledge_n_i, chip_sel_n_i,
    wr_strobe_i, rd_strobe_i, reg_sel_i, data_i};

  dua_sync #(.W(PIN_W)) u_sync (
    .clk_i(core_clk_i),
    .rst_n_i(nrst_i),
    .en_i(clk_en_i),
    .d_i(pin_raw),
    .q_o(pin_s)
  );

  // Edge helpers on synchronised pins
  function automatic logic rise(input logic [PIN_W-1:0] c,
                                input logic [PIN_W-1:0] p, input int i);
    rise = c[i] & ~p[i];
  endfunction
  function automatic logic fall(input logic [PIN_W-1:0] c,
                                input logic [PIN_W-1:0] p, input int i);
    fall = ~c[i] & p[i];
  endfunction

  logic mrst, cs_n_s, wr_take, rd_take, interrupt_acknowledge_n_act;
  logic txc_fall, rxc_rise, ip2_rise;
  logic [2:0] sel;
  logic [7:0] din;
  assign mrst = pin_s[PIN_MRST];
  assign cs_n_s = pin_s[PIN_CS_N];
  assign sel = pin_s[PIN_SEL +: 3];
  assign din = pin_s[PIN_DATA +: 8];
  // Strobes count only with chip select low
  assign wr_take = rise(pin_s, prev_ff, PIN_WR) & ~cs_n_s;
  assign rd_take = rise(pin_s, prev_ff, PIN_RD) & ~cs_n_s;
  assign interrupt_acknowledge_n_act = pin_s[PIN_ZMODE] & ~pin_s[PIN_INTERRUPT_ACKNOWLEDGE_N_N];
  assign txc_fall = fall(pin_s, prev_ff, PIN_TXC);
  assign rxc_rise = rise(pin_s, prev_ff, PIN_RXC);
  assign ip2_rise = rise(pin_s, prev_ff, PIN_IP2);

  // Host-visible registers
  logic [7:0] output_port_value_reg_ff, output_port_config_reg_ff;
  logic [7:0] interrupt_vector_reg_ff, interrupt_mask_reg_ff;
  logic [7:0] mode_ff, channel_status_register, interrupt_status_reg_ff;
  logic [15:0] ct_ff; // Counter/timer
  logic [7:0] nxt_opr, nxt_output_port_config_reg, nxt_ivr, nxt_imr, nxt_mode, nxt_isr;
  logic [15:0] nxt_ct;
  logic ct_step, ct_wrap;

  // Transmitter state
  logic [7:0] div_ff, nxt_div, thr_ff, nxt_thr;
  logic thr_full_ff, nxt_thr_full, txd_ff, nxt_txd, tick;
  logic [9:0] transmit_shift_reg_ff, nxt_tsr;
  logic [3:0] tx_bits_ff, nxt_tx_bits, tx_cnt_ff, nxt_tx_cnt;
  logic tx_load, tx_shift, tx_adv, loop_line;

  // Receiver state; small buffer held locally
  dua_rx_e rx_state_ff, nxt_rx_state;
  logic [3:0] rx_cnt_ff, nxt_rx_cnt, rx_bits_ff, nxt_rx_bits;
  logic [7:0] rx_sh_ff, nxt_rx_sh;
  logic [7:0] fifo_mem [0:3];
  logic [1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [2:0] fcnt_ff, nxt_fcnt;
  logic line, samp, push, pop;

  // Output pin state
  logic [7:0] gen_out_ff, gen_oe_ff, nxt_gen_out, nxt_gen_oe;
  logic [7:0] dout_ff, nxt_dout, rd_val;
  logic doe_ff, nxt_doe, rxb_ff, nxt_rxb;

  // Status view: receive ready, full, transmit ready, empty
  always_comb begin
    channel_status_register = interrupt_status_reg_ff;
    channel_status_register[ST_RXRDY] = (fcnt_ff != 3'h0);
    channel_status_register[ST_FULL] = (fcnt_ff == FIFO_DEPTH);
    channel_status_register[ST_TXRDY] = ~thr_full_ff;
    channel_status_register[ST_TXEMT] = ~thr_full_ff & (tx_bits_ff == 4'h0);
  end

  // Registers and counter/timer next values
  always_comb begin
    nxt_opr = output_port_value_reg_ff;
    nxt_output_port_config_reg = output_port_config_reg_ff;
    nxt_ivr = interrupt_vector_reg_ff;
    nxt_imr = interrupt_mask_reg_ff;
    nxt_mode = mode_ff;
    nxt_isr = interrupt_status_reg_ff;
    nxt_ct = ct_ff;
    ct_step = mode_ff[MODE_CT_RUN] &
              (mode_ff[MODE_CT_EXT] ? ip2_rise : 1'b1);
    ct_wrap = ct_step & (ct_ff == 16'hffff);
    if (ct_step) begin
      nxt_ct = ct_ff + 16'h0001;
    end
    if (wr_take) begin
      case (sel)
        SEL_OPR: nxt_opr = din;
        SEL_OUTPUT_PORT_CONFIG_REG: nxt_output_port_config_reg = din;
        SEL_IVR: nxt_ivr = din;
        SEL_IMR: nxt_imr = din;
        SEL_MODE: nxt_mode = din;
        SEL_STAT: nxt_isr = interrupt_status_reg_ff & ~din; // Ones clear
        default: ;
      endcase
    end
    // Events applied after the clear, so a same-cycle event survives
    if (tx_load) nxt_isr[EV_TXRDY] = 1'b1;
    if (push) nxt_isr[EV_RXRDY] = 1'b1;
    if (ct_wrap) nxt_isr[EV_CT] = 1'b1;
    if (mrst) begin
      nxt_opr = ZERO_RST;
      nxt_output_port_config_reg = ZERO_RST;
      nxt_imr = ZERO_RST;
      nxt_isr = ZERO_RST;
      nxt_ivr = IVR_RST;
      nxt_mode = ZERO_RST;
    end
  end

  // Transmitter next values; 16x tick divider lives here
  always_comb begin
    tick = (div_ff == BAUD_DIV);
    nxt_div = tick ? 8'h00 : div_ff + 8'h01;
    nxt_thr = thr_ff;
    nxt_thr_full = thr_full_ff;
    nxt_tsr = transmit_shift_reg_ff;
    nxt_tx_bits = tx_bits_ff;
    nxt_tx_cnt = (tick && !mode_ff[MODE_TX_EXT]) ? tx_cnt_ff + 4'h1
                                                   : tx_cnt_ff;
    tx_adv = mode_ff[MODE_TX_EXT] ? txc_fall
                                  : (tick && tx_cnt_ff == OVS_LAST);
    tx_load = mode_ff[MODE_TX_EN] & thr_full_ff & (tx_bits_ff == 4'h0);
    tx_shift = !tx_load && tx_bits_ff != 4'h0 && tx_adv;
    if (wr_take && sel == SEL_DATA && !thr_full_ff) begin
      nxt_thr = din;
      nxt_thr_full = 1'b1;
    end
    if (tx_load) begin
      nxt_tsr = {1'b1, thr_ff, 1'b0};
      nxt_tx_bits = TX_FRAME;
      nxt_thr_full = 1'b0;
      nxt_tx_cnt = 4'h0;
    end else if (tx_shift) begin
      nxt_tsr = {1'b1, transmit_shift_reg_ff[9:1]};
      nxt_tx_bits = tx_bits_ff - 4'h1;
    end
    // Disabled aborts the character and marks the line
    if (!mode_ff[MODE_TX_EN]) nxt_tx_bits = 4'h0;
    nxt_txd = (mode_ff[MODE_TX_EN] && !mode_ff[MODE_LOOP] &&
               tx_bits_ff != 4'h0) ? transmit_shift_reg_ff[0] : 1'b1;
    if (mrst) begin
      nxt_thr_full = 1'b0;
      nxt_tx_bits = 4'h0;
      nxt_tsr = 10'h3ff;
      nxt_txd = 1'b1;
    end
  end
  assign loop_line = (tx_bits_ff != 4'h0) ? transmit_shift_reg_ff[0] : 1'b1;

  // Receiver and buffer next values
  always_comb begin
    line = mode_ff[MODE_LOOP] ? loop_line : pin_s[PIN_RXD];
    samp = mode_ff[MODE_RX_EXT] ? rxc_rise
                                : (tick && rx_cnt_ff == OVS_LAST);
    nxt_rx_state = rx_state_ff;
    nxt_rx_cnt = tick ? rx_cnt_ff + 4'h1 : rx_cnt_ff;
    nxt_rx_bits = rx_bits_ff;
    nxt_rx_sh = rx_sh_ff;
    push = 1'b0;
    case (rx_state_ff)
      RX_IDLE: begin
        if (mode_ff[MODE_RX_EXT]) begin
          // Start bit is taken on a single rising edge
          if (rxc_rise && !line) begin
            nxt_rx_state = RX_DATA;
            nxt_rx_bits = 4'h0;
          end
        end else if (tick && !line) begin
          nxt_rx_state = RX_START;
          nxt_rx_cnt = 4'h0;
        end
      end
      RX_START: begin
        // Glitch filter: start must still be low mid-bit
        if (tick && rx_cnt_ff == OVS_MID) begin
          nxt_rx_state = line ? RX_IDLE : RX_DATA;
          nxt_rx_cnt = 4'h0;
          nxt_rx_bits = 4'h0;
        end
      end
      RX_DATA: begin
        if (samp) begin
          nxt_rx_sh = {line, rx_sh_ff[7:1]};
          nxt_rx_bits = rx_bits_ff + 4'h1;
          if (rx_bits_ff == RX_LAST_BIT) nxt_rx_state = RX_STOP;
        end
      end
      RX_STOP: begin
        // Overrun drops the new character, buffer is kept
        if (samp) begin
          push = (fcnt_ff != FIFO_DEPTH);
          nxt_rx_state = RX_IDLE;
        end
      end
      default: nxt_rx_state = RX_IDLE;
    endcase
    if (!mode_ff[MODE_RX_EN] || mrst) begin
      nxt_rx_state = RX_IDLE;
      push = 1'b0;
    end
    pop = rd_take && sel == SEL_DATA && fcnt_ff != 3'h0 && !mrst;
    nxt_wp = push ? wp_ff + 2'h1 : wp_ff;
    nxt_rp = pop ? rp_ff + 2'h1 : rp_ff;
    nxt_fcnt = fcnt_ff + {2'h0, push} - {2'h0, pop};
    if (mrst) begin
      nxt_wp = 2'h0;
      nxt_rp = 2'h0;
      nxt_fcnt = 3'h0;
    end
  end

  // Readback multiplexer
  always_comb begin
    case (sel)
      SEL_DATA: rd_val = fifo_mem[rp_ff];
      SEL_OPR: rd_val = output_port_value_reg_ff;
      SEL_OUTPUT_PORT_CONFIG_REG: rd_val = output_port_config_reg_ff;
      SEL_IVR: rd_val = interrupt_vector_reg_ff;
      SEL_IMR: rd_val = interrupt_status_reg_ff & interrupt_mask_reg_ff;
      SEL_MODE: rd_val = mode_ff;
      SEL_STAT: rd_val = channel_status_register;
      default: rd_val = ct_ff[7:0];
    endcase
  end

  // Pin outputs: port value inverted unless a function is chosen
  always_comb begin
    nxt_gen_out = ~output_port_value_reg_ff;
    nxt_gen_oe = OUT_RST;
    if (output_port_config_reg_ff[OUTPUT_PORT_CONFIG_REG_OP0_RTS]) begin
      nxt_gen_out[0] = ~(tx_bits_ff != 4'h0 || thr_full_ff);
    end
    case (output_port_config_reg_ff[OUTPUT_PORT_CONFIG_REG_OP2_LSB +: 2])
      OP2_TX16: nxt_gen_out[2] = (div_ff <= BAUD_HALF);
      OP2_TX1: nxt_gen_out[2] = mode_ff[MODE_TX_EXT] ? pin_s[PIN_TXC]
                                                     : ~tx_cnt_ff[3];
      OP2_RX1: nxt_gen_out[2] = mode_ff[MODE_RX_EXT] ? pin_s[PIN_RXC]
                                                     : rx_cnt_ff[3];
      default: ;
    endcase
    if (output_port_config_reg_ff[OUTPUT_PORT_CONFIG_REG_OP4_EN]) begin
      // Open drain: only ever pulls low
      nxt_gen_out[4] = 1'b0;
      nxt_gen_oe[4] = output_port_config_reg_ff[OUTPUT_PORT_CONFIG_REG_OP4_FULL] ?
                      channel_status_register[ST_FULL] :
                      channel_status_register[ST_RXRDY];
    end
    nxt_rxb = mode_ff[MODE_RXB_EXT] & pin_s[PIN_IP6];
    nxt_dout = dout_ff;
    nxt_doe = ~cs_n_s & pin_s[PIN_RD];
    if (rd_take) nxt_dout = rd_val;
    if (interrupt_acknowledge_n_act) begin
      nxt_doe = 1'b1;
      nxt_dout = interrupt_vector_reg_ff;
    end
    if (mrst) begin
      nxt_gen_out = OUT_RST;
      nxt_gen_oe = OUT_RST;
      nxt_rxb = 1'b0;
    end
  end

  // All state registers; clock enable freezes everything
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_ff <= '0;
      output_port_value_reg_ff <= ZERO_RST;
      output_port_config_reg_ff <= ZERO_RST;
      interrupt_vector_reg_ff <= IVR_RST;
      interrupt_mask_reg_ff <= ZERO_RST;
      mode_ff <= ZERO_RST;
      interrupt_status_reg_ff <= ZERO_RST;
      ct_ff <= 16'h0000;
      div_ff <= 8'h00;
      thr_ff <= 8'h00;
      thr_full_ff <= 1'b0;
      transmit_shift_reg_ff <= 10'h3ff;
      tx_bits_ff <= 4'h0;
      tx_cnt_ff <= 4'h0;
      txd_ff <= 1'b1;
      rx_state_ff <= RX_IDLE;
      rx_cnt_ff <= 4'h0;
      rx_bits_ff <= 4'h0;
      rx_sh_ff <= 8'h00;
      wp_ff <= 2'h0;
      rp_ff <= 2'h0;
      fcnt_ff <= 3'h0;
      gen_out_ff <= OUT_RST;
      gen_oe_ff <= OUT_RST;
      dout_ff <= 8'h00;
      doe_ff <= 1'b0;
      rxb_ff <= 1'b0;
    end else if (clk_en_i) begin
      prev_ff <= pin_s;
      output_port_value_reg_ff <= nxt_opr;
      output_port_config_reg_ff <= nxt_output_port_config_reg;
      interrupt_vector_reg_ff <= nxt_ivr;
      interrupt_mask_reg_ff <= nxt_imr;
      mode_ff <= nxt_mode;
      interrupt_status_reg_ff <= nxt_isr;
      ct_ff <= nxt_ct;
      div_ff <= nxt_div;
      thr_ff <= nxt_thr;
      thr_full_ff <= nxt_thr_full;
      transmit_shift_reg_ff <= nxt_tsr;
      tx_bits_ff <= nxt_tx_bits;
      tx_cnt_ff <= nxt_tx_cnt;
      txd_ff <= nxt_txd;
      rx_state_ff <= nxt_rx_state;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_bits_ff <= nxt_rx_bits;
      rx_sh_ff <= nxt_rx_sh;
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      fcnt_ff <= nxt_fcnt;
      gen_out_ff <= nxt_gen_out;
      gen_oe_ff <= nxt_gen_oe;
      dout_ff <= nxt_dout;
      doe_ff <= nxt_doe;
      rxb_ff <= nxt_rxb;
    end
  end

  // Buffer storage, no reset needed on data words
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i && push) fifo_mem[wp_ff] <= rx_sh_ff;
  end

  assign data_o = dout_ff;
  assign data_oe_o = doe_ff;
  assign serial_out_a_o = txd_ff;
  assign serial_out_b_o = 1'b1 | ~nrst_i; // Channel B absent: marking
  assign ext_receive_clock_b_o = rxb_ff;
  assign general_outputs_all_o = gen_out_ff;
  assign general_outputs_oe_o = gen_oe_ff;

  // Checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i || !clk_en_i);

  op4_ind_a: assert property (output_port_config_reg_ff[OUTPUT_PORT_CONFIG_REG_OP4_EN] &&
    !output_port_config_reg_ff[OUTPUT_PORT_CONFIG_REG_OP4_FULL] && fcnt_ff != 3'h0 && !mrst
    |=> general_outputs_oe_o[4] && !general_outputs_all_o[4])
    else $error("op4 indicator not asserted");
  op2_txclk_a: assert property (output_port_config_reg_ff[1:0] == OP2_TX1
    && mode_ff[MODE_TX_EXT] && !mrst
    |=> general_outputs_all_o[2] == $past(pin_s[PIN_TXC]))
    else $error("op2 does not follow transmit clock");
  rts_low_a: assert property (output_port_config_reg_ff[OUTPUT_PORT_CONFIG_REG_OP0_RTS] &&
    tx_bits_ff != 4'h0 && !mrst |=> !general_outputs_all_o[0])
    else $error("send request not low while busy");
  lsb_first_a: assert property (tx_shift && !mrst && mode_ff[MODE_TX_EN]
    |=> transmit_shift_reg_ff[8:0] == $past(transmit_shift_reg_ff[9:1]))
    else $error("transmit shift order wrong");
  txd_mark_a: assert property (!mode_ff[MODE_TX_EN] || mode_ff[MODE_LOOP]
    |=> serial_out_a_o)
    else $error("serial output not marking");
  txc_edge_a: assert property (mode_ff[MODE_TX_EXT] && !txc_fall &&
    !tx_load && !mrst |=> $stable(transmit_shift_reg_ff))
    else $error("shift without falling transmit clock");
  rx_lsb_a: assert property (rx_state_ff == RX_DATA && samp && !mrst &&
    mode_ff[MODE_RX_EN] |=> rx_sh_ff[7] == $past(line))
    else $error("received bit not shifted in at top");
  rxc_edge_a: assert property (mode_ff[MODE_RX_EXT] && !rxc_rise
    |=> $stable(rx_sh_ff))
    else $error("sample without rising receive clock");
  mrst_clr_a: assert property (mrst |=> output_port_value_reg_ff == 8'h00 &&
    output_port_config_reg_ff == 8'h00 && interrupt_mask_reg_ff == 8'h00 &&
    interrupt_status_reg_ff == 8'h00)
    else $error("master reset left a register set");
  mrst_ivr_a: assert property (mrst |=> interrupt_vector_reg_ff == 8'h0f)
    else $error("vector not reloaded");
  mrst_out_a: assert property (mrst |=> general_outputs_all_o == 8'hff &&
    !mode_ff[MODE_CT_RUN])
    else $error("outputs not high or timer running");
  mrst_line_a: assert property (mrst ##1 mrst |=> serial_out_a_o &&
    serial_out_b_o && rx_state_ff == RX_IDLE)
    else $error("channel not idle in reset");
  bus_off_a: assert property (cs_n_s && !interrupt_acknowledge_n_act |=> !data_oe_o)
    else $error("bus driven without chip select");
  no_xfer_a: assert property (cs_n_s && !mrst
    |=> $stable(output_port_value_reg_ff))
    else $error("write taken without chip select");
  ct_ext_a: assert property (mode_ff[MODE_CT_EXT] && !ip2_rise && !mrst
    |=> $stable(ct_ff))
    else $error("timer counted without input edge");
  rxb_clk_a: assert property (mode_ff[MODE_RXB_EXT] && !mrst
    |=> ext_receive_clock_b_o == $past(pin_s[PIN_IP6]))
    else $error("channel B clock not passed on");
  interrupt_acknowledge_n_bus_a: assert property (interrupt_acknowledge_n_act && !mrst |=> data_oe_o &&
    data_o == $past(interrupt_vector_reg_ff))
    else $error("vector not driven on acknowledge");
  plain_out_a: assert property (output_port_config_reg_ff == 8'h00 && !mrst
    |=> general_outputs_all_o == ~$past(output_port_value_reg_ff))
    else $error("output does not follow port value");

  char_sent_c: cover property (tx_shift && tx_bits_ff == 4'h1);
  char_rcvd_c: cover property (push);
  interrupt_acknowledge_n_c: cover property (interrupt_acknowledge_n_act ##1 data_oe_o);

endmodule
`default_nettype wire

// File: inc/dua_pkg.sv
// Shared constants for the channel A pin, reset and clock block.
// Assumes a single core clock; all pins but the clock, nrst_i and clk_en_i enter through dua_sync.
package dua_pkg;

  // Character and oversampling
  localparam int unsigned CHAR_W = 8;
  localparam logic [3:0] OVS_LAST = 4'hf; // 16x ticks per bit, last
  localparam logic [3:0] OVS_MID = 4'h7; // Start bit checked mid-bit
  localparam logic [3:0] TX_FRAME = 4'ha; // Start, 8 data, stop
  localparam logic [3:0] RX_LAST_BIT = 4'h7;
  localparam logic [7:0] BAUD_DIV = 8'h0c; // Core cycles per tick, less 1
  localparam logic [7:0] BAUD_HALF = 8'h06; // High half of 16x clock
  localparam logic [2:0] FIFO_DEPTH = 3'h4; // Receive buffer words

  // Host register select codes
  localparam logic [2:0] SEL_DATA = 3'h0;
  localparam logic [2:0] SEL_OPR = 3'h1;
  localparam logic [2:0] SEL_OUTPUT_PORT_CONFIG_REG = 3'h2;
  localparam logic [2:0] SEL_IVR = 3'h3;
  localparam logic [2:0] SEL_IMR = 3'h4;
  localparam logic [2:0] SEL_MODE = 3'h5;
  localparam logic [2:0] SEL_STAT = 3'h6;
  localparam logic [2:0] SEL_CT = 3'h7;

  // Reset values
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam logic [7:0] IVR_RST = 8'h0f;
  localparam logic [7:0] OUT_RST = 8'hff;

  // Mode register fields
  localparam int unsigned MODE_TX_EN = 0;
  localparam int unsigned MODE_RX_EN = 1;
  localparam int unsigned MODE_LOOP = 2;
  localparam int unsigned MODE_TX_EXT = 3;
  localparam int unsigned MODE_RX_EXT = 4;
  localparam int unsigned MODE_CT_RUN = 5;
  localparam int unsigned MODE_CT_EXT = 6;
  localparam int unsigned MODE_RXB_EXT = 7;

  // Output configuration fields and general output 2 sources
  localparam int unsigned OUTPUT_PORT_CONFIG_REG_OP2_LSB = 0;
  localparam int unsigned OUTPUT_PORT_CONFIG_REG_OP4_EN = 2;
  localparam int unsigned OUTPUT_PORT_CONFIG_REG_OP4_FULL = 3;
  localparam int unsigned OUTPUT_PORT_CONFIG_REG_OP0_RTS = 4;
  localparam logic [1:0] OP2_TX16 = 2'h1;
  localparam logic [1:0] OP2_TX1 = 2'h2;
  localparam logic [1:0] OP2_RX1 = 2'h3;

  // Status and event bits
  localparam int unsigned ST_RXRDY = 0;
  localparam int unsigned ST_FULL = 1;
  localparam int unsigned ST_TXRDY = 2;
  localparam int unsigned ST_TXEMT = 3;
  localparam int unsigned EV_TXRDY = 4;
  localparam int unsigned EV_RXRDY = 5;
  localparam int unsigned EV_CT = 6;

  // Synchronised pin vector positions
  localparam int unsigned PIN_DATA = 0;
  localparam int unsigned PIN_SEL = 8;
  localparam int unsigned PIN_RD = 11;
  localparam int unsigned PIN_WR = 12;
  localparam int unsigned PIN_CS_N = 13;
  localparam int unsigned PIN_INTERRUPT_ACKNOWLEDGE_N_N = 14;
  localparam int unsigned PIN_ZMODE = 15;
  localparam int unsigned PIN_MRST = 16;
  localparam int unsigned PIN_RXD = 17;
  localparam int unsigned PIN_TXC = 18;
  localparam int unsigned PIN_RXC = 19;
  localparam int unsigned PIN_IP2 = 20;
  localparam int unsigned PIN_IP6 = 21;
  localparam int unsigned PIN_W = 22;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} dua_rx_e;

endpackage

// File: core/dua_sync.sv
// Two-stage synchroniser for a vector of asynchronous pins.
// Assumes every bit is an independent level; words must be stable.
`timescale 1ns/1ps
`default_nettype none
module dua_sync
  import dua_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_ff; // First stage, read only by second stage
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  // Next values of both stages
  always_comb begin
    nxt_meta = d_i;
    nxt_q = meta_ff;
  end

  // Register, frozen while the enable is low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else if (en_i) begin
      meta_ff <= nxt_meta;
      q_ff <= nxt_q;
    end
  end

  assign q_o = q_ff;

endmodule
`default_nettype wire

// File: verif/dua_remote.sv
// Remote serial device model facing channel A's line pins.
// Assumes 8N1 at 208 core cycles a bit, line idle high.
`timescale 1ns/1ps
`default_nettype none
module dua_remote (
  input wire logic rx_line_i,
  output logic tx_line_o
);
  localparam time BIT_T = 10400; // 208 cycles of 50 ns
  logic [7:0] got; // Last character heard
  initial tx_line_o = 1'b1; // Idle at marking level
  // One character out, low start bit, least bit first
  task automatic send(input logic [7:0] b);
    tx_line_o = 1'b0;
    #BIT_T;
    for (int i = 0; i < 8; i++) begin
      tx_line_o = b[i];
      #BIT_T;
    end
    tx_line_o = 1'b1;
    #BIT_T;
  endtask
  // Listener samples mid-bit so edge jitter cannot bite
  always begin
    @(negedge rx_line_i);
    #(BIT_T * 3 / 2);
    for (int i = 0; i < 8; i++) begin
      got[i] = rx_line_i;
      #BIT_T;
    end
  end
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the channel A pin block.
// Assumes dua_remote on the line side; host bus driven by tasks.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dua_pkg::*;
  logic core_clk_i, nrst_i, mrst, cs_n, rd, wr, zm, interrupt_acknowledge_n_n, sin;
  logic [2:0] sel;
  logic [7:0] din, dout, gpo, gpoe, v;
  logic doe, sa, sb, txc, rxc, ip2, ip6, rxb;
  int n_mismatch = 0;
  int num_checks = 0;
  int k;
  dua_pins dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .clk_en_i(1'b1), .master_reset_i(mrst), .chip_sel_n_i(cs_n),
    .rd_strobe_i(rd), .wr_strobe_i(wr), .reg_sel_i(sel), .data_i(din),
    .z_mode_i(zm), .interrupt_acknowledge_n_i(interrupt_acknowledge_n_n),
    .serial_in_a_i(sin), .ext_transmit_clock_a_i(txc),
    .ext_receive_clock_a_i(rxc), .general_input_2_i(ip2),
    .general_input_6_i(ip6), .data_o(dout), .data_oe_o(doe),
    .serial_out_a_o(sa), .serial_out_b_o(sb), .ext_receive_clock_b_o(rxb),
    .general_outputs_all_o(gpo), .general_outputs_oe_o(gpoe));
  dua_remote rm_u (.rx_line_i(sa), .tx_line_o(sin));
  // 20 MHz core clock
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  task automatic end_sim();
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // Write strobes held 4 cycles, read strobes 5, to clear the pin synchroniser
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    cs_n = 1'b0;
    sel = a;
    din = d;
    wr = 1'b1;
    cyc(4);
    wr = 1'b0;
    cyc(4);
    cs_n = 1'b1;
    cyc(1);
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    cs_n = 1'b0;
    sel = a;
    rd = 1'b1;
    cyc(5);
    d = dout;
    chk({7'h0, doe}, 8'h01);
    rd = 1'b0;
    cyc(4);
    cs_n = 1'b1;
    cyc(1);
  endtask
  // Reset levels, bus released, vector default
  task automatic t_reset();
    chk(gpo, 8'hff);
    chk({6'h0, sa, sb}, 8'h03);
    chk({7'h0, doe}, 8'h00);
    rd_reg(SEL_IVR, v);
    chk(v, IVR_RST);
  endtask
  // Send request and indicator around a transmit and a receive
  task automatic t_serial();
    wr_reg(SEL_MODE, 8'h03);
    wr_reg(SEL_OUTPUT_PORT_CONFIG_REG, 8'h14);
    wr_reg(SEL_DATA, 8'ha5);
    chk({7'h0, gpo[0]}, 8'h00);
    cyc(2400);
    chk(rm_u.got, 8'ha5);
    chk({6'h0, sa, gpo[0]}, 8'h03);
    rm_u.send(8'h3c);
    cyc(20);
    chk({6'h0, gpo[4], gpoe[4]}, 8'h01);
    rd_reg(SEL_DATA, v);
    chk(v, 8'h3c);
    chk({7'h0, gpoe[4]}, 8'h00);
  endtask
  // Loopback keeps the line marking mid-frame
  task automatic t_loop();
    wr_reg(SEL_MODE, 8'h07);
    wr_reg(SEL_DATA, 8'h00);
    cyc(300);
    chk({7'h0, sa}, 8'h01);
  endtask
  // Deselected read, then Z-mode acknowledge without select
  task automatic t_bus();
    rd = 1'b1;
    cyc(5);
    chk({7'h0, doe}, 8'h00);
    rd = 1'b0;
    zm = 1'b1;
    interrupt_acknowledge_n_n = 1'b0;
    cyc(5);
    chk({7'h0, doe}, 8'h01);
    chk(dout, IVR_RST);
    interrupt_acknowledge_n_n = 1'b1;
    zm = 1'b0;
    cyc(5);
  endtask
  // Port value, 16x clock on output 2, then master reset
  task automatic t_mrst();
    wr_reg(SEL_OUTPUT_PORT_CONFIG_REG, 8'h00);
    wr_reg(SEL_OPR, 8'h0b);
    wr_reg(SEL_IVR, 8'h55);
    chk(gpo, 8'hf4);
    wr_reg(SEL_OUTPUT_PORT_CONFIG_REG, 8'h01);
    k = 0;
    repeat (130) begin
      v[0] = gpo[2];
      cyc(1);
      if (!v[0] && gpo[2]) k++;
    end
    chk(8'(k), 8'h0a);
    mrst = 1'b1;
    cyc(4);
    mrst = 1'b0;
    chk(gpo, OUT_RST);
    rd_reg(SEL_OPR, v);
    chk(v, ZERO_RST);
    rd_reg(SEL_IVR, v);
    chk(v, IVR_RST);
  endtask
  // External clocks: falls shift, inputs 2 and 6 serve their functions
  task automatic t_ext();
    logic [8:0] w;
    w = 9'h16c; // Data bits, then the stop bit
    wr_reg(SEL_OUTPUT_PORT_CONFIG_REG, 8'h02);
    wr_reg(SEL_MODE, 8'hf9);
    wr_reg(SEL_DATA, 8'h6c);
    chk({7'h0, sa}, 8'h00);
    for (int i = 0; i < 9; i++) begin
      {txc, rxc, ip2, ip6} = 4'hf;
      cyc(5);
      chk({6'h0, gpo[2], rxb}, 8'h03);
      {txc, rxc, ip2, ip6} = 4'h0;
      cyc(5);
      chk({5'h0, gpo[2], rxb, sa}, {7'h0, w[i]});
    end
    rd_reg(SEL_CT, v);
    chk(v, 8'h09);
  endtask
  initial begin
    #2ms;
    n_mismatch++;
    end_sim();
  end
  initial begin
    {mrst, rd, wr, zm, nrst_i, sel, din} = '0;
    {cs_n, interrupt_acknowledge_n_n} = 2'b11;
    {txc, rxc, ip2, ip6} = 4'h0;
    cyc(3);
    nrst_i = 1'b1;
    cyc(2);
    t_reset();
    t_serial();
    t_loop();
    t_bus();
    t_mrst();
    t_ext();
    end_sim();
  end
endmodule
`default_nettype wire
